// [fps_sequencer.sv]
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`include "fps_defines.svh"
module fps_sequencer (
    input  wire logic               clk_in,
    input  wire logic               sys_rst_in,
    input  wire logic               clk_en_in,
    // avalon-mm slave, word index addressing
    input  wire logic [3:0]         avs_address_in,
    input  wire logic               avs_read_in,
    input  wire logic               avs_write_in,
    input  wire logic [31:0]        avs_writedata_in,
    input  wire logic [3:0]         avs_byteenable_in,
    output logic      [31:0]        avs_readdata_out,
    output logic                    avs_waitrequest_out,
    // mode / protection / array status pins from outside domain
    input  wire logic               mode_allowed_in,
    input  wire logic               pflash_protect_any_in,
    input  wire logic               dflash_protect_any_in,
    input  wire logic [17:0]        prot_lo_in,
    input  wire logic [17:0]        prot_hi_in,
    // flash array handshake
    output logic                    arr_req_out,
    output fps_pkg::fps_arr_t       arr_cmd_out,
    output logic      [17:0]        arr_addr_out,
    output logic      [63:0]        arr_wdata_out,
    output logic                    arr_info_out,
    input  wire logic               arr_done_in,
    input  wire logic [63:0]        arr_rdata_in,
    input  wire logic               arr_err_in,
    input  wire logic               arr_uncorr_in,
    output logic                    pflash_read_invalid_out,
    output logic                    secure_out
);
    import fps_pkg::*;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [1:0] mode_s, pp_s, dp_s;
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mode_s <= 2'h0;
            pp_s   <= 2'h0;
            dp_s   <= 2'h0;
        end else if (clk_en_in) begin
            mode_s <= {mode_s[0], mode_allowed_in};
            pp_s   <= {pp_s[0], pflash_protect_any_in};
            dp_s   <= {dp_s[0], dflash_protect_any_in};
        end
    end
    logic [17:0] plo_a, plo_b, phi_a, phi_b;
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            plo_a <= 18'h0;
            plo_b <= 18'h0;
            phi_a <= 18'h0;
            phi_b <= 18'h0;
        end else if (clk_en_in) begin
            plo_a <= prot_lo_in;
            plo_b <= plo_a;
            phi_a <= prot_hi_in;
            phi_b <= phi_a;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [15:0] param [0:5];
    logic [2:0]  slot;
    logic        ccf, acc, pv, ve, vu, secured;
    fps_state_t  state;
    logic        busy;
    logic        launch;
    logic        bus_wr, bus_rd;
    logic        ack;

    assign busy   = (state != FPS_IDLE);
    assign bus_wr = avs_write_in && clk_en_in && !ack;
    assign bus_rd = avs_read_in && clk_en_in && !ack;
    assign avs_waitrequest_out = !ack;
    // launch by writing one to the complete flag while no access or protection error pending
    assign launch = bus_wr && !busy && ccf && avs_byteenable_in[0]
                    && (avs_address_in == `FPS_REG_STAT)
                    && avs_writedata_in[`FPS_ST_CCF] && !acc && !pv;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ack <= 1'b0;
        end else if (clk_en_in) begin
            ack <= (avs_read_in || avs_write_in) && !ack;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            avs_readdata_out <= 32'h0;
        end else if (bus_rd) begin
            unique case (avs_address_in)
                `FPS_REG_STAT: avs_readdata_out <= {24'h0, ccf, 1'b0, acc, pv, 2'h0, ve, vu};
                `FPS_REG_IDX:  avs_readdata_out <= {29'h0, slot};
                `FPS_REG_DATA: avs_readdata_out <= (slot < 3'h6) ? {16'h0, param[slot]} : 32'h0;
                `FPS_REG_SEC:  avs_readdata_out <= {31'h0, secured};
                default:       avs_readdata_out <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            slot <= 3'h0;
        end else if (bus_wr && !busy && avs_address_in == `FPS_REG_IDX) begin
            slot <= avs_writedata_in[2:0];
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < 6; i++) param[i] <= 16'h0;
        end else if (bus_wr && !busy && avs_address_in == `FPS_REG_DATA && slot < 3'h6) begin
            param[slot] <= avs_writedata_in[15:0];
        end
    end

    // ----------------------------------------
    // launch checks
    // ----------------------------------------
    logic [7:0]  opc;
    logic [17:0] gaddr;
    logic [63:0] wdata;
    logic        is_pgm, is_once, is_erall;
    logic        e_acc, e_pv;
    assign opc   = param[0][15:8];
    assign gaddr = {param[0][1:0], param[1]};
    assign wdata = {param[2], param[3], param[4], param[5]};
    assign is_pgm   = (opc == `FPS_OP_PGM);
    assign is_once  = (opc == `FPS_OP_ONCE);
    assign is_erall = (opc == `FPS_OP_ERALL);

    always_comb begin
        e_acc = 1'b0;
        e_pv  = 1'b0;
        if (!mode_s[1]) e_acc = 1'b1;
        if (is_pgm) begin
            if (slot != `FPS_IDX_PGM) e_acc = 1'b1;
            if (gaddr[2:0] != 3'h0) e_acc = 1'b1;
            if (gaddr < `FPS_PFLASH_LO) e_acc = 1'b1;
            if (gaddr >= plo_b && gaddr <= phi_b) e_pv = 1'b1;
        end else if (is_once) begin
            if (slot != `FPS_IDX_PGM) e_acc = 1'b1;
            if (param[1] > `FPS_ONCE_MAX) e_acc = 1'b1;
        end else if (is_erall) begin
            if (slot != `FPS_IDX_ERALL) e_acc = 1'b1;
            if (pp_s[1] || dp_s[1]) e_pv = 1'b1;
        end else begin
            e_acc = 1'b1;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state   <= FPS_IDLE;
            ccf     <= 1'b1;
            acc     <= 1'b0;
            pv      <= 1'b0;
            ve      <= 1'b0;
            vu      <= 1'b0;
            secured <= 1'b1;
        end else if (clk_en_in) begin
            if (bus_wr && !busy && avs_address_in == `FPS_REG_STAT) begin
                if (avs_writedata_in[`FPS_ST_ACC]) acc <= 1'b0;
                if (avs_writedata_in[`FPS_ST_PV])  pv  <= 1'b0;
            end
            unique case (state)
                FPS_IDLE: if (launch) begin
                    ccf   <= 1'b0;
                    ve    <= 1'b0;
                    vu    <= 1'b0;
                    state <= FPS_CHECK;
                end
                FPS_CHECK: begin
                    if (e_acc || e_pv) begin
                        acc   <= e_acc;
                        pv    <= e_pv;
                        state <= FPS_DONE;
                    end else begin
                        state <= FPS_OP;
                    end
                end
                FPS_OP: if (arr_done_in) begin
                    if (is_once && arr_cmd_out == FPS_ARR_BLANK
                        && arr_rdata_in != 64'hffff_ffff_ffff_ffff) begin
                        acc   <= 1'b1;
                        state <= FPS_DONE;
                    end else if (arr_cmd_out == FPS_ARR_BLANK) begin
                        state <= FPS_OP;
                    end else begin
                        state <= FPS_VERIFY;
                    end
                end
                FPS_VERIFY: if (arr_done_in) begin
                    if (arr_err_in || (!is_erall && arr_rdata_in != wdata)) begin
                        ve    <= 1'b1;
                    end
                    if (arr_uncorr_in) vu <= 1'b1;
                    if (is_erall && !arr_err_in && !arr_uncorr_in) secured <= 1'b0;
                    state <= FPS_DONE;
                end
                FPS_DONE: begin
                    ccf   <= 1'b1;
                    state <= FPS_IDLE;
                end
                default: state <= FPS_IDLE;
            endcase
        end
    end

    // array step selection; blank check precedes program once
    logic blank_done;
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            blank_done <= 1'b0;
        end else if (clk_en_in) begin
            if (state == FPS_CHECK) blank_done <= 1'b0;
            else if (state == FPS_OP && arr_done_in && arr_cmd_out == FPS_ARR_BLANK)
                blank_done <= 1'b1;
        end
    end

    always_comb begin
        arr_cmd_out = FPS_ARR_PROG;
        if (state == FPS_OP && is_once && !blank_done) arr_cmd_out = FPS_ARR_BLANK;
        else if (state == FPS_OP && is_erall) arr_cmd_out = FPS_ARR_ERALL;
        else if (state == FPS_VERIFY) arr_cmd_out = FPS_ARR_READ;
    end
    assign arr_req_out   = (state == FPS_OP) || (state == FPS_VERIFY);
    assign arr_info_out  = is_once && busy;
    assign arr_addr_out  = is_once ? {12'h0, param[1][2:0], 3'h0} : gaddr;
    assign arr_wdata_out = wdata;
    assign pflash_read_invalid_out = is_once && busy;
    assign secure_out    = secured;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    ccf_low_busy_a: assert property (busy && state != FPS_DONE |-> !ccf)
        else $error("complete flag high while busy");
    done_ccf_a: assert property (
        state == FPS_DONE && clk_en_in |=> ccf && state == FPS_IDLE)
        else $error("complete flag not set at end");
    misalign_acc_a: assert property (
        state == FPS_CHECK && clk_en_in && is_pgm && gaddr[2:0] != 3'h0 |=> acc)
        else $error("misaligned address not flagged");
    slot_acc_a: assert property (
        state == FPS_CHECK && clk_en_in && (is_pgm || is_once) && slot != 3'h5 |=> acc)
        else $error("bad slot index not flagged");
    mode_acc_a: assert property (state == FPS_CHECK && clk_en_in && !mode_s[1] |=> acc)
        else $error("mode violation not flagged");
    range_acc_a: assert property (
        state == FPS_CHECK && clk_en_in && is_pgm && gaddr < `FPS_PFLASH_LO |=> acc)
        else $error("unmapped address not flagged");
    prot_pv_a: assert property (
        state == FPS_CHECK && clk_en_in && is_pgm && gaddr >= plo_b && gaddr <= phi_b |=> pv)
        else $error("protected address not flagged");
    verify_err_a: assert property (
        state == FPS_VERIFY && clk_en_in && arr_done_in && arr_err_in |=> ve)
        else $error("verify error not flagged");
    verify_unc_a: assert property (
        state == FPS_VERIFY && clk_en_in && arr_done_in && arr_uncorr_in |=> vu)
        else $error("uncorrectable error not flagged");
    once_blank_a: assert property (
        state == FPS_CHECK && clk_en_in && is_once && !e_acc && !e_pv
        |=> arr_cmd_out == FPS_ARR_BLANK)
        else $error("program once skipped blank check");
    once_idx_a: assert property (
        state == FPS_CHECK && clk_en_in && is_once && param[1] > 16'h0007 |=> acc)
        else $error("bad phrase index not flagged");
    once_used_a: assert property (
        state == FPS_OP && clk_en_in && arr_done_in && is_once && arr_cmd_out == FPS_ARR_BLANK
        && arr_rdata_in != 64'hffff_ffff_ffff_ffff |=> acc && state == FPS_DONE)
        else $error("programmed phrase not refused");
    ones_reuse_a: assert property (
        state == FPS_OP && clk_en_in && arr_done_in && is_once && arr_cmd_out == FPS_ARR_BLANK
        && arr_rdata_in == 64'hffff_ffff_ffff_ffff |=> state == FPS_OP && blank_done)
        else $error("all ones phrase refused");
    read_inv_a: assert property (busy && is_once |-> pflash_read_invalid_out)
        else $error("reads not invalid during program once");
    once_info_a: assert property (
        arr_req_out && is_once |-> arr_info_out && arr_addr_out[17:6] == 12'h0)
        else $error("program once left reserved field");
    erall_cmd_a: assert property (
        state == FPS_OP && is_erall |-> arr_cmd_out == FPS_ARR_ERALL && !arr_info_out)
        else $error("erase all issued wrong array step");
    sec_rel_a: assert property ($fell(secure_out) |-> $past(is_erall))
        else $error("security released by wrong command");
    sec_hold_a: assert property (
        state == FPS_VERIFY && clk_en_in && arr_done_in && (arr_err_in || arr_uncorr_in)
        |=> $stable(secure_out))
        else $error("security released after failed verify");
    erall_slot_a: assert property (
        state == FPS_CHECK && clk_en_in && is_erall && slot != 3'h0 |=> acc)
        else $error("erase all slot index not flagged");
    erall_pv_a: assert property (
        state == FPS_CHECK && clk_en_in && is_erall && !e_acc && (pp_s[1] || dp_s[1]) |=> pv)
        else $error("protection not flagged on erase all");
    skip_array_a: assert property (
        state == FPS_CHECK && (e_acc || e_pv) && clk_en_in |=> !arr_req_out ##1 ccf)
        else $error("array touched after launch error");

    // ----------------------------------------
    // cover points
    // ----------------------------------------
    pgm_cov_c:   cover property (state == FPS_VERIFY && is_pgm && arr_done_in);
    once_cov_c:  cover property (state == FPS_OP && is_once && blank_done);
    erall_cov_c: cover property ($fell(secure_out));
    err_cov_c:   cover property (state == FPS_CHECK && e_acc);
    verr_cov_c:  cover property (state == FPS_VERIFY && arr_done_in && arr_err_in);
endmodule : fps_sequencer

// [fps_defines.svh]
// Function
// - program phrase then verify, complete after
// - phrase address low three bits zero
// - program commands need slot index five
// - command refused in disallowed mode
// - program address must map to flash
// - program address in protected region errors
// - any verify error sets verify bit
// - uncorrectable verify error sets second bit
// - program once checks erased, programs, verifies
// - program once index zero to seven
// - programmed once phrase refused
// - all ones phrase may reprogram
// - flash reads invalid during program once
// - program once limited to reserved field
// - erase all, verify, then complete
// - successful erase all releases security
// - erase all needs slot index zero
// - erase all refused if protected
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH
`define FPS_REG_STAT      4'h0
`define FPS_REG_IDX       4'h1
`define FPS_REG_DATA      4'h2
`define FPS_REG_CTRL      4'h3
`define FPS_REG_SEC       4'h4
`define FPS_OP_PGM        8'h06
`define FPS_OP_ONCE       8'h07
`define FPS_OP_ERALL      8'h08
`define FPS_IDX_PGM       3'h5
`define FPS_IDX_ERALL     3'h0
`define FPS_ONCE_MAX      16'h0007
`define FPS_ST_CCF        7
`define FPS_ST_ACC        5
`define FPS_ST_PV         4
`define FPS_ST_VE         1
`define FPS_ST_VU         0
`define FPS_PFLASH_LO     18'h30000
`define FPS_RESET_STAT    8'h80
`endif

// [fps_pkg.sv]
package fps_pkg;
    typedef enum logic [2:0] {
        FPS_IDLE, FPS_CHECK, FPS_OP, FPS_VERIFY, FPS_DONE
    } fps_state_t;
    typedef enum logic [1:0] {
        FPS_ARR_PROG, FPS_ARR_BLANK, FPS_ARR_ERALL, FPS_ARR_READ
    } fps_arr_t;
endpackage : fps_pkg

// [fps_flash_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// flash array model
// ----------------------------------------
module fps_flash_model (
    input  wire logic              clk_in,
    input  wire logic              req_in,
    input  wire fps_pkg::fps_arr_t cmd_in,
    input  wire logic [17:0]       addr_in,
    input  wire logic [63:0]       wdata_in,
    input  wire logic              info_in,
    input  wire logic [3:0]        lat_in,
    input  wire logic [1:0]        fault_in,
    output logic                   done_out,
    output logic [63:0]            rdata_out,
    output logic                   err_out,
    output logic                   uncorr_out
);
    import fps_pkg::*;
    logic [63:0] pf [logic [17:0]];
    logic [63:0] inf [logic [17:0]];
    logic [63:0] last = 64'h0;
    logic [3:0]  cnt = 4'h0;
    logic        busy = 1'b0;
    int          n_prog = 0;
    initial begin
        done_out = 1'b0;
        rdata_out = 64'h0;
        err_out = 1'b0;
        uncorr_out = 1'b0;
    end
    always @(posedge clk_in) begin
        if (done_out) begin
            // released read bus shows inverted data
            done_out <= 1'b0;
            err_out <= 1'b0;
            uncorr_out <= 1'b0;
            rdata_out <= ~last;
            busy <= 1'b0;
        end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (busy) begin
            done_out <= 1'b1;
            case (cmd_in)
                FPS_ARR_PROG: begin
                    if (info_in) inf[addr_in] = wdata_in;
                    else pf[addr_in] = wdata_in;
                    n_prog++;
                end
                // info field survives erase
                FPS_ARR_ERALL: pf.delete();
                default: begin
                    if (info_in) last = inf.exists(addr_in) ? inf[addr_in] : '1;
                    else last = pf.exists(addr_in) ? pf[addr_in] : '1;
                    rdata_out <= last;
                    err_out <= fault_in[0] && cmd_in == FPS_ARR_READ;
                    uncorr_out <= fault_in[1] && cmd_in == FPS_ARR_READ;
                end
            endcase
        end else if (req_in) begin
            busy <= 1'b1;
            cnt <= lat_in;
        end
    end
endmodule : fps_flash_model

// [test_flash_program_erase_sequencer.sv]
`timescale 1ns/100ps
`include "fps_defines.svh"
module test_flash_program_erase_sequencer;
    import fps_pkg::*;
    logic        clk_in = 1'b0, sys_rst_in = 1'b1, clk_en_in = 1'b1;
    logic [3:0]  avs_address_in = 4'h0, avs_byteenable_in = 4'hf;
    logic        avs_read_in = 1'b0, avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
    logic        avs_waitrequest_out, mode_allowed_in = 1'b1;
    logic        pflash_protect_any_in = 1'b0, dflash_protect_any_in = 1'b0;
    logic [17:0] prot_lo_in = 18'h3ff00, prot_hi_in = 18'h3ffff, arr_addr_out;
    logic        arr_req_out, arr_info_out, arr_done_in, arr_err_in, arr_uncorr_in;
    fps_arr_t    arr_cmd_out;
    logic [63:0] arr_wdata_out, arr_rdata_in;
    logic        pflash_read_invalid_out, secure_out;
    logic [3:0]  lat = 4'h1;
    logic [1:0]  fault = 2'h0;
    logic [7:0]  st;
    int          bad_count = 0, n_checks = 0, inv_cnt = 0;
    fps_sequencer fps_sequencer_inst (.clk_in, .sys_rst_in, .clk_en_in, .avs_address_in,
        .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
        .avs_readdata_out, .avs_waitrequest_out, .mode_allowed_in, .pflash_protect_any_in,
        .dflash_protect_any_in, .prot_lo_in, .prot_hi_in, .arr_req_out, .arr_cmd_out,
        .arr_addr_out, .arr_wdata_out, .arr_info_out, .arr_done_in, .arr_rdata_in,
        .arr_err_in, .arr_uncorr_in, .pflash_read_invalid_out, .secure_out);
    fps_flash_model fps_flash_model_inst (.clk_in, .req_in(arr_req_out),
        .cmd_in(arr_cmd_out), .addr_in(arr_addr_out), .wdata_in(arr_wdata_out),
        .info_in(arr_info_out), .lat_in(lat), .fault_in(fault), .done_out(arr_done_in),
        .rdata_out(arr_rdata_in), .err_out(arr_err_in), .uncorr_out(arr_uncorr_in));
    always #4 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (pflash_read_invalid_out === 1'b1) inv_cnt <= inv_cnt + 1;
    end
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address_in   <= a;
        avs_writedata_in <= d;
        avs_write_in     <= wr;
        avs_read_in      <= !wr;
        // request stands until the edge that samples waitrequest low
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
        @(posedge clk_in);
    endtask : bus
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8
    task automatic chk64(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk64
    task automatic run(input logic [7:0] op, input logic [17:0] a, input logic [15:0] w,
                       input logic [2:0] ix);
        int n;
        n = 0;
        bus(1'b1, `FPS_REG_IDX, 32'h0);
        bus(1'b1, `FPS_REG_DATA, {16'h0, op, 6'h0, a[17:16]});
        for (int s = 1; s < 6 && op != `FPS_OP_ERALL; s++) begin
            bus(1'b1, `FPS_REG_IDX, s);
            bus(1'b1, `FPS_REG_DATA, {16'h0, s == 1 ? a[15:0] : w});
        end
        bus(1'b1, `FPS_REG_IDX, {29'h0, ix});
        bus(1'b1, `FPS_REG_STAT, 32'h80);
        do begin
            bus(1'b0, `FPS_REG_STAT, 32'h0);
            n++;
        end while (rd[`FPS_ST_CCF] !== 1'b1 && n < 100);
        st = rd[7:0];
        if (n >= 100) begin
            bad_count++;
            test_done;
        end
        bus(1'b1, `FPS_REG_STAT, 32'h30);
    endtask : run
    task automatic t_err(input logic [7:0] op, input logic [17:0] a, input logic [2:0] ix,
                         input logic m, input logic [7:0] e);
        int np;
        np = fps_flash_model_inst.n_prog;
        mode_allowed_in <= m;
        run(op, a, 16'h0f0f, ix);
        mode_allowed_in <= 1'b1;
        @(posedge clk_in);
        chk8("error status", e, st);
        chk64("array writes", np, fps_flash_model_inst.n_prog);
    endtask : t_err
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        bus(1'b0, `FPS_REG_STAT, 32'h0);
        chk8("reset status", `FPS_RESET_STAT, rd[7:0]);
        chk64("reset secure", 64'h1, {63'h0, secure_out});
        // frozen clock enable holds off the answer
        clk_en_in <= 1'b0;
        fork
            bus(1'b0, `FPS_REG_STAT, 32'h0);
            begin
                repeat (6) @(posedge clk_in);
                chk8("frozen waitrequest", 8'h01, {7'h0, avs_waitrequest_out});
                clk_en_in <= 1'b1;
            end
        join
        chk8("status after freeze", `FPS_RESET_STAT, rd[7:0]);
        bus(1'b1, 4'h3, 32'hffff_ffff);
        bus(1'b0, 4'h3, 32'h0);
        chk8("unused register", 8'h00, rd[7:0]);
        bus(1'b0, `FPS_REG_STAT, 32'h0);
        chk8("status after unused", `FPS_RESET_STAT, rd[7:0]);
    endtask : t_reset
    task automatic t_prog;
        lat <= 4'h6;
        run(`FPS_OP_PGM, 18'h30008, 16'ha5c3, `FPS_IDX_PGM);
        chk8("program status", 8'h80, st);
        chk64("phrase", {4{16'ha5c3}}, fps_flash_model_inst.pf[18'h30008]);
        fault <= 2'b01;
        run(`FPS_OP_PGM, 18'h30010, 16'h1111, `FPS_IDX_PGM);
        chk8("verify error", 8'h82, st);
        fault <= 2'b11;
        run(`FPS_OP_PGM, 18'h30018, 16'h2222, `FPS_IDX_PGM);
        chk8("uncorrectable", 8'h83, st);
        fault <= 2'b00;
        lat <= 4'h1;
    endtask : t_prog
    task automatic t_once;
        int n0;
        n0 = inv_cnt;
        // bench never fetches from the array
        run(`FPS_OP_ONCE, 18'h3, 16'h1234, `FPS_IDX_PGM);
        chk8("once status", 8'h80, st);
        chk64("read invalid", 64'h1, {63'h0, inv_cnt > n0});
        chk64("info phrases", 64'h1, fps_flash_model_inst.inf.num());
        t_err(`FPS_OP_ONCE, 18'h3, `FPS_IDX_PGM, 1'b1, 8'ha0);
        run(`FPS_OP_ONCE, 18'h5, 16'hffff, `FPS_IDX_PGM);
        run(`FPS_OP_ONCE, 18'h5, 16'h2222, `FPS_IDX_PGM);
        chk8("once over ones", 8'h80, st);
    endtask : t_once
    task automatic t_errors;
        t_err(`FPS_OP_PGM, 18'h30009, `FPS_IDX_PGM, 1'b1, 8'ha0);
        t_err(`FPS_OP_PGM, 18'h30020, 3'h4, 1'b1, 8'ha0);
        t_err(`FPS_OP_PGM, 18'h30020, `FPS_IDX_PGM, 1'b0, 8'ha0);
        t_err(`FPS_OP_PGM, 18'h00100, `FPS_IDX_PGM, 1'b1, 8'ha0);
        t_err(`FPS_OP_PGM, 18'h3ff08, `FPS_IDX_PGM, 1'b1, 8'h90);
        t_err(`FPS_OP_ONCE, 18'h1, 3'h4, 1'b1, 8'ha0);
        t_err(`FPS_OP_ONCE, 18'h1, `FPS_IDX_PGM, 1'b0, 8'ha0);
        t_err(`FPS_OP_ONCE, 18'h8, `FPS_IDX_PGM, 1'b1, 8'ha0);
        t_err(`FPS_OP_ERALL, 18'h0, 3'h1, 1'b1, 8'ha0);
        t_err(`FPS_OP_ERALL, 18'h0, `FPS_IDX_ERALL, 1'b0, 8'ha0);
    endtask : t_errors
    task automatic t_erall;
        pflash_protect_any_in <= 1'b1;
        run(`FPS_OP_ERALL, 18'h0, 16'h0, `FPS_IDX_ERALL);
        chk8("erase p protected", 8'h90, st);
        pflash_protect_any_in <= 1'b0;
        dflash_protect_any_in <= 1'b1;
        run(`FPS_OP_ERALL, 18'h0, 16'h0, `FPS_IDX_ERALL);
        chk8("erase d protected", 8'h90, st);
        chk64("secure kept", 64'h1, {63'h0, secure_out});
        dflash_protect_any_in <= 1'b0;
        run(`FPS_OP_ERALL, 18'h0, 16'h0, `FPS_IDX_ERALL);
        chk8("erase all", 8'h80, st);
        chk64("flash left", 64'h0, fps_flash_model_inst.pf.num());
        chk64("info left", 64'h2, fps_flash_model_inst.inf.num());
        chk64("secure released", 64'h0, {63'h0, secure_out});
    endtask : t_erall
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    // watchdog well beyond the expected thousand or so cycles
    initial begin
        #480000;
        bad_count++;
        test_done;
    end
    initial begin
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        t_reset;
        t_prog;
        t_once;
        t_errors;
        t_erall;
        test_done;
    end
endmodule : test_flash_program_erase_sequencer
